// >>> verilog/cam_angle_setting_ui.sv
// Operator editing of four programmable cam channel angles.
//
// Notes on behaviour
// - Four cam channels each hold an on and an off angle, editable from the display.
// - Angle changes are refused while the press is running.
// - In edit mode the carry-up segment means on angle and the fine-jog segment off angle.
// - Each advance press moves to the next segment, showing the channel tag and angle.
// - Holding the key at plus raises the selected angle, at minus lowers it.
// - The LED ring lights an arc from the on angle that follows angle changes.
// - After the on angle the next advance selects the same channel's off angle.
// - The sequence continues through channels two to four, each with its tag.
// - While editing is enabled, lower-half display settings cannot be adjusted.
// - With the enable cleared, the next advance selects the angle-and-rate segment.
// - Option switch one or the display-board switch enables editing; off by default.
`timescale 1ns/10ps
`default_nettype none
module cam_angle_setting_ui #(
  parameter int REPEAT_CYC = cam_set_pkg::REPEAT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Switches and press state, asynchronous pins
  input wire logic option_switch_bank_1,
  input wire logic display_edit_switch,
  input wire logic inch_mode,
  input wire logic press_running,
  input wire logic advance_button,
  input wire logic key_plus,
  input wire logic key_minus,
  // Display
  output logic edit_enabled,
  output logic cam_on_segment,
  output logic cam_off_segment,
  output logic angle_rate_segment,
  output logic lower_half_lock,
  output logic [2:0] channel_tag,
  output logic [8:0] shown_angle,
  output logic [cam_set_pkg::RING_LEDS-1:0] ring,
  // Stored settings for the cam output generator
  output logic [4*9-1:0] on_angles,
  output logic [4*9-1:0] off_angles
);
  localparam int NIN = 7;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [NIN-1:0] pins;
  logic [NIN-1:0] sync1_reg;
  logic [NIN-1:0] sync2_reg;
  assign pins = {key_minus, key_plus, advance_button, press_running,
                 inch_mode, display_edit_switch, option_switch_bank_1};
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  logic en_sw;
  logic inch_s;
  logic run_s;
  logic adv_s;
  logic plus_s;
  logic minus_s;
  assign en_sw = sync2_reg[0] | sync2_reg[1];
  assign inch_s = sync2_reg[2];
  assign run_s = sync2_reg[3];
  assign adv_s = sync2_reg[4];
  assign plus_s = sync2_reg[5];
  assign minus_s = sync2_reg[6];

  logic adv_d_reg;
  logic adv_pulse;
  always_ff @(posedge mclk) begin
    if (reset) begin
      adv_d_reg <= 1'b0;
    end else begin
      adv_d_reg <= adv_s;
    end
  end
  assign adv_pulse = adv_s & ~adv_d_reg;

  // ----------------------------------------------------------------
  // Selection sequence
  // ----------------------------------------------------------------
  cam_set_pkg::sel_t sel_reg;
  cam_set_pkg::sel_t sel_next;
  logic [1:0] chan_reg;
  logic [1:0] chan_next;
  logic edit_ok;
  // Edits need the enable, inch mode and a stopped press.
  assign edit_ok = en_sw & inch_s & ~run_s;

  // Clearing the enable drops any cam selection at once, so a stale channel
  // is never left lit while the normal display is back in charge.
  always_comb begin
    sel_next = sel_reg;
    chan_next = chan_reg;
    if (adv_pulse) begin
      if (!en_sw) begin
        sel_next = cam_set_pkg::SEL_RATE;
        chan_next = 2'h0;
      end else begin
        case (sel_reg)
          cam_set_pkg::SEL_ON: begin
            sel_next = cam_set_pkg::SEL_OFF;
          end
          cam_set_pkg::SEL_OFF: begin
            sel_next = cam_set_pkg::SEL_ON;
            chan_next = chan_reg + 2'h1;
          end
          default: begin
            sel_next = cam_set_pkg::SEL_ON;
            chan_next = 2'h0;
          end
        endcase
      end
    end else if (!en_sw && sel_reg != cam_set_pkg::SEL_RATE) begin
      sel_next = cam_set_pkg::SEL_NONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sel_reg <= cam_set_pkg::SEL_NONE;
      chan_reg <= 2'h0;
    end else begin
      sel_reg <= sel_next;
      chan_reg <= chan_next;
    end
  end

  // ----------------------------------------------------------------
  // Key repeat timing
  // ----------------------------------------------------------------
  // A held key steps once at once, then once per repeat interval, so a
  // brief turn moves one degree while holding slews the angle.
  logic [$clog2(REPEAT_CYC+1)-1:0] rep_reg;
  logic step;
  logic key_held;
  assign key_held = plus_s ^ minus_s;
  assign step = key_held && rep_reg == '0;
  always_ff @(posedge mclk) begin
    if (reset) begin
      rep_reg <= '0;
    end else if (!key_held) begin
      rep_reg <= '0;
    end else if (rep_reg == '0) begin
      rep_reg <= ($clog2(REPEAT_CYC+1))'(REPEAT_CYC - 1);
    end else begin
      rep_reg <= rep_reg - 1'b1;
    end
  end

  function automatic logic [8:0] bump(input logic [8:0] a, input logic up);
    logic [8:0] r;
    r = a;
    if (up) begin
      r = (a >= cam_set_pkg::ANGLE_MAX) ? 9'h000 : a + 9'h001;
    end else begin
      r = (a == 9'h000) ? cam_set_pkg::ANGLE_MAX : a - 9'h001;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Angle storage
  // ----------------------------------------------------------------
  logic [8:0] on_reg [cam_set_pkg::CHANNELS];
  logic [8:0] off_reg [cam_set_pkg::CHANNELS];
  logic do_edit;
  assign do_edit = step & edit_ok;

  genvar c;
  generate
    for (c = 0; c < cam_set_pkg::CHANNELS; c++) begin : g_chan
      always_ff @(posedge mclk) begin
        if (reset) begin
          on_reg[c] <= cam_set_pkg::ON_RESET;
          off_reg[c] <= cam_set_pkg::OFF_RESET;
        end else if (do_edit && chan_reg == 2'(c)) begin
          if (sel_reg == cam_set_pkg::SEL_ON) begin
            on_reg[c] <= bump(on_reg[c], plus_s);
          end
          if (sel_reg == cam_set_pkg::SEL_OFF) begin
            off_reg[c] <= bump(off_reg[c], plus_s);
          end
        end
      end
      assign on_angles[c*9 +: 9] = on_reg[c];
      assign off_angles[c*9 +: 9] = off_reg[c];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Display outputs
  // ----------------------------------------------------------------
  // Only an on or off selection puts a cam channel on the display.
  function automatic logic angle_sel(input cam_set_pkg::sel_t s);
    return s == cam_set_pkg::SEL_ON || s == cam_set_pkg::SEL_OFF;
  endfunction

  logic [8:0] cur_on;
  logic [8:0] cur_off;
  assign cur_on = on_reg[chan_reg];
  assign cur_off = off_reg[chan_reg];

  // The lower half stays locked for as long as either enable is on, so an
  // operator who forgets to clear the enable cannot change those settings.
  always_ff @(posedge mclk) begin
    if (reset) begin
      edit_enabled <= 1'b0;
      lower_half_lock <= 1'b0;
    end else begin
      edit_enabled <= en_sw;
      lower_half_lock <= en_sw;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cam_on_segment <= 1'b0;
      cam_off_segment <= 1'b0;
      angle_rate_segment <= 1'b0;
    end else begin
      cam_on_segment <= sel_reg == cam_set_pkg::SEL_ON;
      cam_off_segment <= sel_reg == cam_set_pkg::SEL_OFF;
      angle_rate_segment <= sel_reg == cam_set_pkg::SEL_RATE;
    end
  end

  // The display is blanked outside a cam selection rather than left
  // showing the last channel, so a reader never mistakes it for live data.
  always_ff @(posedge mclk) begin
    if (reset) begin
      channel_tag <= 3'h0;
      shown_angle <= 9'h000;
    end else if (angle_sel(sel_reg)) begin
      channel_tag <= {1'b0, chan_reg} + 3'h1;
      shown_angle <= (sel_reg == cam_set_pkg::SEL_ON) ? cur_on : cur_off;
    end else begin
      channel_tag <= 3'h0;
      shown_angle <= 9'h000;
    end
  end

  // ----------------------------------------------------------------
  // Crank-angle ring
  // ----------------------------------------------------------------
  // The ring lags the stored angle by one clock, which no operator sees.
  logic show_arc;
  assign show_arc = angle_sel(sel_reg);

  cam_arc_ring #(
    .LEDS(cam_set_pkg::RING_LEDS)
  ) u_ring (
    .mclk(mclk),
    .reset(reset),
    .show(show_arc),
    .on_angle(cur_on),
    .off_angle(cur_off),
    .ring(ring)
  );
endmodule
`default_nettype wire

// >>> verilog/cam_set_pkg.sv
// Constants shared by the cam angle editing logic.
`default_nettype none
package cam_set_pkg;
  localparam int CHANNELS = 4;
  localparam int ANGLE_W = 9;
  localparam logic [8:0] ANGLE_MAX = 9'h167;
  localparam logic [8:0] ON_RESET = 9'h000;
  localparam logic [8:0] OFF_RESET = 9'h000;
  localparam int RING_LEDS = 36;
  localparam logic [8:0] DEG_PER_LED = 9'h00a;
  localparam int REPEAT_MS = 200;
  localparam int CLK_KHZ = 25000;
  localparam int REPEAT_CYC = REPEAT_MS * CLK_KHZ;
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_ON,
    SEL_OFF,
    SEL_RATE
  } sel_t;
endpackage
`default_nettype wire

// >>> verilog/cam_arc_ring.sv
// Crank-angle LED ring arc from an on angle to an off angle.
`timescale 1ns/10ps
`default_nettype none
module cam_arc_ring #(
  parameter int LEDS = cam_set_pkg::RING_LEDS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Arc ends
  input wire logic show,
  input wire logic [8:0] on_angle,
  input wire logic [8:0] off_angle,
  // Ring
  output logic [LEDS-1:0] ring
);
  logic [LEDS-1:0] ring_next;
  genvar i;
  generate
    for (i = 0; i < LEDS; i++) begin : g_led
      localparam logic [8:0] POS = 9'(i * 10);
      always_comb begin
        if (!show) begin
          ring_next[i] = 1'b0;
        end else if (on_angle <= off_angle) begin
          ring_next[i] = (POS >= on_angle) && (POS <= off_angle);
        end else begin
          ring_next[i] = (POS >= on_angle) || (POS <= off_angle);
        end
      end
    end
  endgenerate
  // LEDs at the arc end follow the angle as it moves.
  always_ff @(posedge mclk) begin
    if (reset) begin
      ring <= '0;
    end else begin
      ring <= ring_next;
    end
  end
endmodule
`default_nettype wire

// >>> dv/cam_angle_setting_ui_checker.sv
// Assertion checker for the cam angle editing block.
`timescale 1ns/10ps
`default_nettype none
module cam_angle_setting_ui_checker (
  // Clock, reset and pins
  input wire logic mclk,
  input wire logic reset,
  input wire logic option_switch_bank_1,
  input wire logic inch_mode,
  input wire logic press_running,
  // Display and storage
  input wire logic edit_enabled,
  input wire logic cam_on_segment,
  input wire logic cam_off_segment,
  input wire logic angle_rate_segment,
  input wire logic lower_half_lock,
  input wire logic [2:0] channel_tag,
  input wire logic [8:0] shown_angle,
  input wire logic [4*9-1:0] off_angles
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  seg_excl_a: assert property (!(cam_on_segment && cam_off_segment))
    else $error("on and off segments lit together");
  lock_edit_a: assert property (lower_half_lock == edit_enabled)
    else $error("lock differs from edit enable");
  tag_range_a: assert property ((cam_on_segment || cam_off_segment) |->
    channel_tag inside {[3'h1:3'h4]}) else $error("bad channel tag");
  idle_show_a: assert property (!(cam_on_segment || cam_off_segment) |->
    channel_tag == 3'h0 && shown_angle == 9'h000) else $error("idle display not blank");
  run_freeze_a: assert property (press_running [*4] |=> $stable(off_angles))
    else $error("angle changed while running");
  inch_gate_a: assert property (!inch_mode [*4] |=> $stable(off_angles))
    else $error("angle changed outside inch");
  enable_on_a: assert property (option_switch_bank_1 [*3] |=> edit_enabled)
    else $error("option switch did not enable");
  rate_only_a: assert property (angle_rate_segment |-> !cam_on_segment &&
    !cam_off_segment && channel_tag == 3'h0) else $error("rate segment shares display");
  angle_max_a: assert property (shown_angle <= cam_set_pkg::ANGLE_MAX)
    else $error("angle above range");
  cover property (channel_tag == 3'h4 && cam_off_segment);
  cover property (angle_rate_segment);
  cover property (shown_angle == cam_set_pkg::ANGLE_MAX);
endmodule
bind cam_angle_setting_ui cam_angle_setting_ui_checker cam_angle_setting_ui_checker_i (
  .mclk(mclk), .reset(reset), .option_switch_bank_1(option_switch_bank_1),
  .inch_mode(inch_mode), .press_running(press_running), .edit_enabled(edit_enabled),
  .cam_on_segment(cam_on_segment), .cam_off_segment(cam_off_segment),
  .angle_rate_segment(angle_rate_segment), .lower_half_lock(lower_half_lock),
  .channel_tag(channel_tag), .shown_angle(shown_angle), .off_angles(off_angles));
`default_nettype wire

// >>> dv/operator_model.sv
// Operator at the front display: advance button and key switch.
`timescale 1ns/10ps
`default_nettype none
module operator_model (
  // Clock
  input wire logic mclk,
  // Requests from the bench
  input wire logic press_req,
  input wire logic [1:0] key_req,
  // Front panel contacts
  output logic advance_button = 1'b0,
  output logic key_plus = 1'b0,
  output logic key_minus = 1'b0
);
  // Contacts move a clock after the request, on the rising edge, through nonblocking assignments.
  always @(posedge mclk) begin
    advance_button <= press_req;
    key_plus <= key_req[0];
    key_minus <= key_req[1];
  end
endmodule
`default_nettype wire

// >>> dv/tb_cam_angle_setting_ui.sv
// Self-checking bench for the cam angle editing block.
`timescale 1ns/10ps
`default_nettype none
module tb_cam_angle_setting_ui;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic opt_sw = 1'b0;
  logic disp_sw = 1'b0;
  logic inch = 1'b0;
  logic running = 1'b0;
  logic press_req = 1'b0;
  logic [1:0] key_req = 2'h0;
  logic adv, kp, km, edit, seg_on, seg_off, seg_rate, lock;
  logic [2:0] tag;
  logic [8:0] angle;
  logic [35:0] ring, on_a, off_a;
  int fails = 0;
  int num_checks = 0;
  // Rows: one advance press each, expected {tag, on segment, off segment}.
  logic [4:0] rows [0:8] = '{5'h06, 5'h05, 5'h0a, 5'h09, 5'h0e, 5'h0d, 5'h12, 5'h11, 5'h06};
  cam_angle_setting_ui #(.REPEAT_CYC(4)) cam_angle_setting_ui_i (
    .mclk(mclk), .reset(reset), .option_switch_bank_1(opt_sw),
    .display_edit_switch(disp_sw), .inch_mode(inch), .press_running(running),
    .advance_button(adv), .key_plus(kp), .key_minus(km), .edit_enabled(edit),
    .cam_on_segment(seg_on), .cam_off_segment(seg_off), .angle_rate_segment(seg_rate),
    .lower_half_lock(lock), .channel_tag(tag), .shown_angle(angle), .ring(ring),
    .on_angles(on_a), .off_angles(off_a));
  operator_model operator_model_i (.mclk(mclk), .press_req(press_req), .key_req(key_req),
    .advance_button(adv), .key_plus(kp), .key_minus(km));
  initial forever #20 mclk = ~mclk;
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // A key held four cycles gives exactly one step with the short repeat interval.
  task automatic step(input logic p, input logic [1:0] k);
    press_req <= p;
    key_req <= k;
    repeat (4) @(posedge mclk);
    press_req <= 1'b0;
    key_req <= 2'h0;
    repeat (9) @(posedge mclk);
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge mclk);
    fails++;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk("edit", 1'b0, edit);
    chk("tag", 3'h0, tag);
    $display("reset test done");
    opt_sw <= 1'b1;
    inch <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("lock", 1'b1, lock);
    for (int i = 0; i < 9; i++) begin
      step(1'b1, 2'h0);
      chk("select", rows[i], {tag, seg_on, seg_off});
    end
    $display("advance table done");
    step(1'b0, 2'h2);
    chk("wrap down", 9'h167, angle);
    step(1'b0, 2'h1);
    chk("wrap up", 9'h000, on_a[8:0]);
    step(1'b1, 2'h0);
    step(1'b0, 2'h1);
    chk("off angle", 9'h001, off_a[8:0]);
    chk("ring", 2'h1, ring[1:0]);
    running <= 1'b1;
    repeat (4) @(posedge mclk);
    step(1'b0, 2'h1);
    chk("running", 9'h001, off_a[8:0]);
    running <= 1'b0;
    inch <= 1'b0;
    repeat (4) @(posedge mclk);
    step(1'b0, 2'h1);
    chk("not inch", 9'h001, off_a[8:0]);
    $display("edit tests done");
    opt_sw <= 1'b0;
    disp_sw <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("display switch", 1'b1, edit);
    disp_sw <= 1'b0;
    step(1'b1, 2'h0);
    chk("rate", 1'b1, seg_rate);
    $display("exit test done");
    end_of_test;
  end
endmodule
`default_nettype wire
